// >>> mailbox_device.sv
`default_nettype none
// Function
// R1: buffer free exactly when visible free set
// R2: keep avail, free, hidden shadow free
// R3: setting shadow also sets visible free
// R4: shadow clear or first write clears both
// R5: clearing visible free keeps shadow
// R6: visible set fails while shadow clear
// R7: host raises request, tests free, abandons
// R8: host writes size, bytes, drops request
// R9: device clears free, tests shadow
// R10: request high: retry free set, wait
// R11: request low: clear shadow, fill, avail
// R12: first read clears avail; done frees
// R13: all zero after write: drain, free
// R14: host checks avail before sending
// R15: busy host waits, polls avail
// R16: device samples request within write
// R17: request fall may trigger send early
// R18: one domain; host write clear wins
module mailbox_device (
    mailbox_if.device link,
    input wire logic tx_req_i,
    input wire mailbox_pkg::size_t tx_len_i,
    input wire mailbox_pkg::byte_t tx_seed_i,
    input wire logic early_start_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    output logic tx_done_o,
    output logic rx_valid_o,
    output mailbox_pkg::byte_t rx_data_o
);
    import mailbox_pkg::*;
    localparam logic [3:0] ADR_STATUS = 4'h0;
    localparam logic [3:0] ADR_IRQ = 4'h4;
    localparam logic [3:0] ADR_MASK = 4'h8;
    localparam logic [2:0] IRQ_SENT = 3'h1;
    localparam logic [2:0] IRQ_RECV = 3'h2;
    localparam logic [2:0] IRQ_BACKOFF = 3'h4;
    typedef enum logic [2:0] {D_IDLE, D_TEST, D_FILL, D_WAIT_READ, D_DRAIN} dstate_e;
    dstate_e state_reg;
    byte_t mem_reg [BUF_DEPTH];
    size_t len_reg, cnt_reg, host_len_reg, tx_len_reg;
    byte_t seed_reg;
    logic shadow_free_reg, free_reg, avail_reg;
    logic [7:0] poll_reg;
    logic pending_reg, hreq_d_reg, host_wrote_reg;
    logic [2:0] irq_stat_reg, irq_mask_reg;
    logic poll_now, set_free, clr_free_only, clr_shadow, read_done;
    logic [2:0] events;
    function automatic idx_t to_idx(input size_t v);
        return v[IDX_W-1:0];
    endfunction
    assign link.buffer_free_flag = free_reg; // see R1
    assign link.data_avail_flag = avail_reg; // see R2
    assign link.rd_size = len_reg;
    assign link.rd_data = mem_reg[to_idx(cnt_reg)];
    //////////////////////////////////////////////////////////////
    // poll timer, early start on request fall
    assign poll_now = poll_reg == '0 || (early_start_i && hreq_d_reg && !link.host_request_bit); // see R17
    always_ff @(posedge link.ref_clk_i or posedge link.reset_i) begin
        if (link.reset_i) begin
            poll_reg <= POLL_CYCLES;
            hreq_d_reg <= 1'b0;
            pending_reg <= 1'b0;
            seed_reg <= '0;
            tx_len_reg <= '0;
        end else begin
            poll_reg <= (poll_reg == '0) ? POLL_CYCLES : poll_reg - 8'h01;
            hreq_d_reg <= link.host_request_bit;
            if (tx_req_i && !pending_reg) begin
                pending_reg <= 1'b1;
                seed_reg <= tx_seed_i;
                tx_len_reg <= (tx_len_i > size_t'(BUF_DEPTH - 1)) ? size_t'(BUF_DEPTH - 1) : tx_len_i;
            end else if (state_reg == D_TEST && shadow_free_reg && !link.host_request_bit) begin
                pending_reg <= 1'b0;
            end
        end
    end
    //////////////////////////////////////////////////////////////
    // send and drain sequence
    assign read_done = state_reg == D_WAIT_READ && host_wrote_reg;
    always_comb begin
        set_free = 1'b0;
        clr_free_only = 1'b0;
        clr_shadow = 1'b0;
        if (state_reg == D_IDLE && pending_reg && poll_now && !avail_reg && free_reg) begin
            clr_free_only = 1'b1; // see R9
        end
        if (state_reg == D_TEST && shadow_free_reg) begin
            if (link.host_request_bit) begin
                set_free = 1'b1; // see R10
            end else begin
                clr_shadow = 1'b1; // see R11
            end
        end
        if (read_done || (state_reg == D_DRAIN && cnt_reg == host_len_reg)) begin
            set_free = 1'b1; // see R12 R13
        end
    end
    always_ff @(posedge link.ref_clk_i or posedge link.reset_i) begin
        if (link.reset_i) begin
            shadow_free_reg <= 1'b1;
            free_reg <= 1'b1;
        end else if (link.first_wr || clr_shadow) begin
            shadow_free_reg <= 1'b0; // see R4 R18
            free_reg <= 1'b0;
        end else if (clr_free_only) begin
            free_reg <= 1'b0; // see R5
        end else if (set_free) begin
            free_reg <= shadow_free_reg || state_reg != D_TEST; // see R6
            shadow_free_reg <= shadow_free_reg || state_reg != D_TEST; // see R3
        end
    end
    always_ff @(posedge link.ref_clk_i or posedge link.reset_i) begin
        if (link.reset_i) begin
            state_reg <= D_IDLE;
            cnt_reg <= '0;
            len_reg <= '0;
            avail_reg <= 1'b0;
            host_wrote_reg <= 1'b0;
            tx_done_o <= 1'b0;
            rx_valid_o <= 1'b0;
            rx_data_o <= '0;
            host_len_reg <= '0;
            for (int i = 0; i < BUF_DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
        end else begin
            tx_done_o <= 1'b0;
            rx_valid_o <= 1'b0;
            if (link.wr_stb) begin
                mem_reg[to_idx(link.first_wr ? '0 : cnt_reg)] <= link.wr_data;
                cnt_reg <= link.first_wr ? 5'h01 : cnt_reg + 5'h01;
                if (link.first_wr) begin
                    host_len_reg <= link.wr_data[SIZE_W-1:0];
                end
            end
            if (link.first_rd) begin
                avail_reg <= 1'b0; // see R12
            end
            case (state_reg)
                D_IDLE: begin
                    if (clr_free_only) begin
                        state_reg <= D_TEST;
                    end else if (!avail_reg && !shadow_free_reg && !link.host_request_bit && !link.wr_stb) begin
                        state_reg <= D_DRAIN; // see R13
                        cnt_reg <= 5'h01;
                    end
                end
                D_TEST: begin
                    // sampled once, in the single cycle spent in D_TEST
                    state_reg <= (shadow_free_reg && !link.host_request_bit) ? D_FILL : D_IDLE; // see R16
                    cnt_reg <= '0;
                    len_reg <= tx_len_reg;
                end
                D_FILL: begin
                    mem_reg[to_idx(cnt_reg)] <= (cnt_reg == '0) ? byte_t'(len_reg) : seed_reg + byte_t'(cnt_reg);
                    cnt_reg <= cnt_reg + 5'h01;
                    if (cnt_reg == len_reg) begin
                        avail_reg <= 1'b1; // see R11
                        cnt_reg <= 5'h01;
                        state_reg <= D_WAIT_READ;
                        host_wrote_reg <= 1'b0;
                    end
                end
                D_WAIT_READ: begin
                    if (link.rd_stb && cnt_reg >= len_reg) begin
                        host_wrote_reg <= 1'b1;
                    end else if (link.first_rd) begin
                        cnt_reg <= 5'h02;
                    end else if (link.rd_stb) begin
                        cnt_reg <= cnt_reg + 5'h01;
                    end
                    if (read_done) begin
                        state_reg <= D_IDLE;
                        tx_done_o <= 1'b1;
                    end
                end
                D_DRAIN: begin
                    rx_valid_o <= 1'b1;
                    rx_data_o <= mem_reg[to_idx(cnt_reg)];
                    cnt_reg <= cnt_reg + 5'h01;
                    if (cnt_reg == host_len_reg) begin
                        state_reg <= D_IDLE;
                    end
                end
                default: state_reg <= D_IDLE;
            endcase
            if (state_reg == D_WAIT_READ && link.first_rd) begin
                cnt_reg <= 5'h02;
            end
        end
    end
    //////////////////////////////////////////////////////////////
    // wishbone status, interrupts
    assign events = {state_reg == D_TEST && set_free, state_reg == D_DRAIN && cnt_reg == host_len_reg, read_done};
    always_ff @(posedge link.ref_clk_i or posedge link.reset_i) begin
        if (link.reset_i) begin
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            irq_stat_reg <= irq_stat_reg | events;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
                wb_dat_o <= '0;
                if (wb_adr_i == ADR_STATUS) begin
                    wb_dat_o <= {26'h0, state_reg != D_IDLE, link.host_request_bit, pending_reg,
                        shadow_free_reg, free_reg, avail_reg};
                end else if (wb_adr_i == ADR_IRQ) begin
                    wb_dat_o <= {29'h0, irq_stat_reg};
                    if (wb_we_i && wb_sel_i[0]) begin
                        irq_stat_reg <= (irq_stat_reg & ~wb_dat_i[2:0]) | events;
                    end
                end else if (wb_adr_i == ADR_MASK) begin
                    wb_dat_o <= {29'h0, irq_mask_reg};
                    if (wb_we_i && wb_sel_i[0]) begin
                        irq_mask_reg <= wb_dat_i[2:0];
                    end
                end
            end
        end
    end
    assign irq_o = |(irq_stat_reg & ~irq_mask_reg);
endmodule
`default_nettype wire

// >>> mailbox_pkg.sv
`default_nettype none
package mailbox_pkg;
    localparam int BUF_DEPTH = 16;
    localparam int IDX_W = 4;
    localparam int SIZE_W = 5;
    localparam logic [SIZE_W-1:0] MIN_HOST_LEN = 5'h03;
    localparam logic [7:0] POLL_CYCLES = 8'h10;
    typedef logic [7:0] byte_t;
    typedef logic [IDX_W-1:0] idx_t;
    typedef logic [SIZE_W-1:0] size_t;
endpackage
`default_nettype wire

// >>> mailbox_if.sv
`default_nettype none
interface mailbox_if (
    input wire logic ref_clk_i,
    input wire logic reset_i
);
    import mailbox_pkg::*;
    logic data_avail_flag;
    logic buffer_free_flag;
    logic host_request_bit;
    logic wr_stb;
    logic first_wr;
    logic last_wr;
    byte_t wr_data;
    logic rd_stb;
    logic first_rd;
    byte_t rd_data;
    size_t rd_size;
    modport device (
        input ref_clk_i, reset_i, host_request_bit, wr_stb, first_wr, last_wr, wr_data, rd_stb, first_rd,
        output data_avail_flag, buffer_free_flag, rd_data, rd_size
    );
    modport host (
        input ref_clk_i, reset_i, data_avail_flag, buffer_free_flag, rd_data, rd_size,
        output host_request_bit, wr_stb, first_wr, last_wr, wr_data, rd_stb, first_rd
    );
endinterface
`default_nettype wire

// >>> mailbox_host.sv
`default_nettype none
module mailbox_host (
    mailbox_if.host link,
    input wire logic send_i,
    input wire mailbox_pkg::size_t send_len_i,
    input wire mailbox_pkg::byte_t send_seed_i,
    output logic busy_o,
    output logic sent_o,
    output logic refused_o,
    output logic rx_valid_o,
    output mailbox_pkg::byte_t rx_data_o,
    output logic rx_last_o
);
    import mailbox_pkg::*;
    typedef enum logic [2:0] {H_IDLE, H_REQ, H_TEST, H_WRITE, H_DROP, H_READ} hstate_e;
    hstate_e state_reg;
    size_t cnt_reg, len_reg;
    byte_t seed_reg;
    logic sent_reg, refused_reg;
    assign busy_o = state_reg != H_IDLE;
    assign sent_o = sent_reg;
    assign refused_o = refused_reg;
    //////////////////////////////////////////////////////////////
    // request, test, write or read
    always_ff @(posedge link.ref_clk_i or posedge link.reset_i) begin
        if (link.reset_i) begin
            state_reg <= H_IDLE;
            cnt_reg <= '0;
            len_reg <= '0;
            seed_reg <= '0;
            link.host_request_bit <= 1'b0;
            sent_reg <= 1'b0;
            refused_reg <= 1'b0;
        end else begin
            sent_reg <= 1'b0;
            refused_reg <= 1'b0;
            case (state_reg)
                H_IDLE: begin
                    if (link.data_avail_flag) begin // see R14
                        state_reg <= H_READ;
                        cnt_reg <= '0;
                    end else if (send_i) begin
                        link.host_request_bit <= 1'b1; // see R7
                        len_reg <= (send_len_i < MIN_HOST_LEN) ? MIN_HOST_LEN : send_len_i;
                        seed_reg <= send_seed_i;
                        state_reg <= H_REQ;
                    end
                end
                H_REQ: state_reg <= H_TEST;
                H_TEST: begin
                    if (link.buffer_free_flag && !link.data_avail_flag) begin // see R8
                        state_reg <= H_WRITE;
                        cnt_reg <= '0;
                    end else begin
                        link.host_request_bit <= 1'b0; // see R7
                        refused_reg <= 1'b1; // see R15
                        state_reg <= H_IDLE;
                    end
                end
                H_WRITE: begin
                    cnt_reg <= cnt_reg + 5'h01;
                    if (cnt_reg == len_reg) begin
                        state_reg <= H_DROP;
                    end
                end
                H_DROP: begin
                    link.host_request_bit <= 1'b0; // see R8
                    sent_reg <= 1'b1;
                    state_reg <= H_IDLE;
                end
                H_READ: begin
                    cnt_reg <= cnt_reg + 5'h01;
                    if (cnt_reg != '0 && cnt_reg >= link.rd_size) begin
                        state_reg <= H_IDLE;
                    end
                end
                default: state_reg <= H_IDLE;
            endcase
        end
    end
    //////////////////////////////////////////////////////////////
    // byte strobes: byte 0 is size, then payload
    always_comb begin
        link.wr_stb = state_reg == H_WRITE;
        link.first_wr = link.wr_stb && cnt_reg == '0;
        link.last_wr = link.wr_stb && cnt_reg == len_reg;
        link.wr_data = (cnt_reg == '0) ? byte_t'(len_reg) : seed_reg + byte_t'(cnt_reg);
        link.rd_stb = state_reg == H_READ && cnt_reg != '0;
        link.first_rd = link.rd_stb && cnt_reg == 5'h01;
    end
    always_ff @(posedge link.ref_clk_i or posedge link.reset_i) begin
        if (link.reset_i) begin
            rx_valid_o <= 1'b0;
            rx_data_o <= '0;
            rx_last_o <= 1'b0;
        end else begin
            rx_valid_o <= link.rd_stb;
            rx_data_o <= link.rd_data;
            rx_last_o <= link.rd_stb && cnt_reg >= link.rd_size;
        end
    end
endmodule
`default_nettype wire

// >>> mailbox_properties.sv
`default_nettype none
module mailbox_properties (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic data_avail_flag,
    input wire logic buffer_free_flag,
    input wire logic host_request_bit,
    input wire logic wr_stb,
    input wire logic first_wr,
    input wire logic last_wr,
    input wire logic rd_stb,
    input wire logic first_rd
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    ////////////////////////////////////////
    AST_FIRST_WR_CLEARS: assert property (first_wr |=> !buffer_free_flag)
        else $error("free still set after first write");
    AST_WRITE_HOLDS_BUFFER: assert property (wr_stb && !first_wr |-> !buffer_free_flag)
        else $error("free set during host write");
    AST_FIRST_RD_CLEARS: assert property (first_rd |=> !data_avail_flag)
        else $error("avail still set after first read");
    AST_AVAIL_MEANS_BUSY: assert property (data_avail_flag |-> !buffer_free_flag)
        else $error("avail and free both set");
    AST_FREE_RISE_IDLE: assert property ($rose(buffer_free_flag) |-> !data_avail_flag && !wr_stb && !rd_stb)
        else $error("free set while buffer in use");
    AST_WRITE_UNDER_REQUEST: assert property (wr_stb |-> host_request_bit)
        else $error("host write without request");
    AST_REQUEST_DROPS: assert property (last_wr |-> ##[1:8] !host_request_bit)
        else $error("request held after write");
    AST_REFUSED_DROPS: assert property ($rose(host_request_bit) ##1 !buffer_free_flag |-> ##[1:4] !host_request_bit)
        else $error("request held after busy test");
    AST_NO_WRITE_ON_AVAIL: assert property (first_wr |-> !data_avail_flag)
        else $error("host writes over device data");
    AST_READ_OWNED: assert property (rd_stb |-> !buffer_free_flag && !wr_stb)
        else $error("read while buffer free");
    ////////////////////////////////////////
    cover property (first_wr);
    cover property ($rose(data_avail_flag));
    cover property ($rose(host_request_bit) ##1 !buffer_free_flag);
endmodule
`default_nettype wire

// >>> single_buffer_flag_handshake_test.sv
`default_nettype none
`define CHK(nm, g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module single_buffer_flag_handshake_test import mailbox_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_i = 1'h0, reset_i = 1'h1, send_i = 1'h0, tx_req_i = 1'h0, early_start_i = 1'h0;
    logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    size_t send_len_i = 5'h03, tx_len_i = 5'h03;
    byte_t send_seed_i = 8'h00, tx_seed_i = 8'h00, h_rx_data, d_rx_data;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic busy_o, sent_o, refused_o, h_rx_valid, h_rx_last, wb_ack_o, irq_o, tx_done_o, d_rx_valid;
    int mismatches = 0, samples_checked = 0, lasts = 0, dsent = 0;
    byte_t host_exp[$], host_got[$], dev_exp[$], dev_got[$];
    ////////////////////////////////////////
    mailbox_if i_mailbox_if (.ref_clk_i(ref_clk_i), .reset_i(reset_i));
    mailbox_host i_mailbox_host (.link(i_mailbox_if), .send_i(send_i), .send_len_i(send_len_i),
        .send_seed_i(send_seed_i), .busy_o(busy_o), .sent_o(sent_o), .refused_o(refused_o),
        .rx_valid_o(h_rx_valid), .rx_data_o(h_rx_data), .rx_last_o(h_rx_last));
    mailbox_device i_mailbox_device (.link(i_mailbox_if), .tx_req_i(tx_req_i), .tx_len_i(tx_len_i),
        .tx_seed_i(tx_seed_i), .early_start_i(early_start_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .irq_o(irq_o), .tx_done_o(tx_done_o), .rx_valid_o(d_rx_valid), .rx_data_o(d_rx_data));
    mailbox_properties i_mailbox_properties (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .data_avail_flag(i_mailbox_if.data_avail_flag), .buffer_free_flag(i_mailbox_if.buffer_free_flag),
        .host_request_bit(i_mailbox_if.host_request_bit), .wr_stb(i_mailbox_if.wr_stb),
        .first_wr(i_mailbox_if.first_wr), .last_wr(i_mailbox_if.last_wr), .rd_stb(i_mailbox_if.rd_stb),
        .first_rd(i_mailbox_if.first_rd));
    ////////////////////////////////////////
    initial forever #50 ref_clk_i = ~ref_clk_i;
    initial begin
        #(100 * 60000);
        mismatches++;
        tally_and_finish();
    end
    always @(posedge ref_clk_i) begin
        if (d_rx_valid === 1'h1) dev_got.push_back(d_rx_data);
        if (h_rx_valid === 1'h1) host_got.push_back(h_rx_data);
        if (h_rx_last === 1'h1) lasts++;
    end
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do begin @(posedge ref_clk_i); n++; end while (wb_ack_o !== 1'h1 && n < 20);
        if (n == 20) mismatches++;
        q = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask
    task automatic wait_free();
        int n;
        n = 0;
        do begin wb(1'h0, 4'h0, 32'h0); n++; end while (q[1] !== 1'h1 && n < 300);
        repeat (4) @(posedge ref_clk_i);
    endtask
    task automatic host_send(input int len, input byte_t sd);
        int n;
        repeat (10) begin
            n = 0;
            while (busy_o !== 1'h0 && n < 3000) begin @(posedge ref_clk_i); n++; end
            @(posedge ref_clk_i);
            send_i <= 1'h1;
            send_len_i <= size_t'(len);
            send_seed_i <= sd;
            @(posedge ref_clk_i);
            send_i <= 1'h0;
            n = 0;
            do begin @(posedge ref_clk_i); n++; end while (sent_o !== 1'h1 && refused_o !== 1'h1 && n < 3000);
            if (sent_o === 1'h1) begin
                for (int k = 0; k < len; k++) dev_exp.push_back(byte_t'(sd + k + 1));
                return;
            end
            repeat (POLL_CYCLES) @(posedge ref_clk_i);
        end
        mismatches++;
    endtask
    task automatic dev_send(input int len, input byte_t sd);
        int n;
        @(posedge ref_clk_i);
        tx_req_i <= 1'h1;
        tx_len_i <= size_t'(len);
        tx_seed_i <= sd;
        @(posedge ref_clk_i);
        tx_req_i <= 1'h0;
        for (int k = 0; k < len; k++) host_exp.push_back(byte_t'(sd + k + 1));
        dsent++;
        n = 0;
        do begin @(posedge ref_clk_i); n++; end while (tx_done_o !== 1'h1 && n < 5000);
        if (n == 5000) mismatches++;
    endtask
    task automatic cmp_q(input string nm, ref byte_t e[$], ref byte_t g[$]);
        `CHK(nm, g.size(), e.size())
        for (int k = 0; k < e.size() && k < g.size(); k++) `CHK(nm, g[k], e[k])
        e.delete();
        g.delete();
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        void'($urandom(69455));
        repeat (12) @(posedge ref_clk_i);
        reset_i <= 1'h0;
        wb(1'h0, 4'h0, 32'h0);
        `CHK("status_reset", q[5:0], 6'h06)
        wb(1'h1, 4'h8, 32'h0);
        for (int i = 0; i < 4; i++) begin
            host_send(3 + $urandom % 13, byte_t'($urandom));
            wait_free();
            `CHK("free_shadow_drained", q[2:0], 3'h6)
            cmp_q("host_to_dev", dev_exp, dev_got);
        end
        `CHK("irq_level", irq_o, 1'h1)
        wb(1'h0, 4'h4, 32'h0);
        `CHK("irq_recv", q[1], 1'h1)
        wb(1'h1, 4'h8, 32'h7);
        `CHK("irq_masked", irq_o, 1'h0)
        wb(1'h1, 4'h4, 32'h7);
        wb(1'h0, 4'h4, 32'h0);
        `CHK("irq_cleared", q[2:0], 3'h0)
        wb(1'h1, 4'h8, 32'h0);
        `CHK("irq_idle", irq_o, 1'h0)
        wb(1'h0, 4'hC, 32'h0);
        `CHK("unmapped", q, 32'h0)
        for (int i = 0; i < 3; i++) begin
            dev_send(1 + $urandom % 15, byte_t'($urandom));
            wait_free();
            `CHK("free_after_read", q[2:0], 3'h6)
            cmp_q("dev_to_host", host_exp, host_got);
            `CHK("last_count", lasts, dsent)
        end
        for (int e = 0; e < 2; e++) begin
            early_start_i <= e[0];
            fork
                host_send(3 + $urandom % 13, byte_t'($urandom));
                dev_send(1 + $urandom % 15, byte_t'($urandom));
            join
            wait_free();
            cmp_q("race_host_to_dev", dev_exp, dev_got);
            cmp_q("race_dev_to_host", host_exp, host_got);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
